// File: logic/tdr_top.sv
// Function
// - ov high byte, read-only at 0x05C2
// - ov low byte, read-only at 0x05C3
// - reported value is 0.8 of threshold
// - high read freezes low until both read
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
`include "tdr_regs.svh"

module tdr_top (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [15:0] ov_thresh_i,
    input  wire logic [15:0] uv_thresh_i,
    input  wire logic        ov_conv_i,
    input  wire logic        uv_conv_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [17:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic [31:0]      prdata_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } tdr_state_s;

    tdr_state_s state_r;
    tdr_state_s state_nxt;

    tdr_pkg::tdr_conv_s ov_conv;
    tdr_pkg::tdr_conv_s uv_conv;
    tdr_pkg::tdr_pair_s ov_pair;
    tdr_pkg::tdr_pair_s uv_pair;
    logic [15:0]        idx;
    logic               setup;
    logic               rd_ov_high;
    logic               rd_ov_low;
    logic               rd_uv_high;
    logic               rd_uv_low;
    logic [19:0]        ov_prod;
    logic [19:0]        uv_prod;

    // ------------------------------------------------------------
    // dac output model: 0.8 times threshold
    // ------------------------------------------------------------
    assign ov_prod = 20'(ov_thresh_i) * 20'(`TDR_SCALE_NUM);
    assign uv_prod = 20'(uv_thresh_i) * 20'(`TDR_SCALE_NUM);
    assign ov_conv.valid  = ov_conv_i;
    assign ov_conv.result = 16'(ov_prod / 20'(`TDR_SCALE_DEN));
    assign uv_conv.valid  = uv_conv_i;
    assign uv_conv.result = 16'(uv_prod / 20'(`TDR_SCALE_DEN));

    // ------------------------------------------------------------
    // apb decode; read takes effect in setup, answer next cycle
    // ------------------------------------------------------------
    assign idx   = paddr_i[17:2];
    assign setup = psel_i && !penable_i && !pwrite_i
                   && paddr_i[1:0] == 2'h0;
    assign rd_ov_high = setup && idx == `TDR_OV_HIGH_IDX;
    assign rd_ov_low  = setup && idx == `TDR_OV_LOW_IDX;
    assign rd_uv_high = setup && idx == `TDR_UV_HIGH_IDX;
    assign rd_uv_low  = setup && idx == `TDR_UV_LOW_IDX;

    // readback pairs
    tdr_pair #(
        .HIGH_RST (`TDR_OV_HIGH_RST),
        .LOW_RST  (`TDR_OV_LOW_RST)
    ) u_ov_pair (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .conv_i    (ov_conv),
        .rd_high_i (rd_ov_high),
        .rd_low_i  (rd_ov_low),
        .pair_o    (ov_pair)
    );

    tdr_pair #(
        .HIGH_RST (`TDR_UV_HIGH_RST),
        .LOW_RST  (`TDR_UV_LOW_RST)
    ) u_uv_pair (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .conv_i    (uv_conv),
        .rd_high_i (rd_uv_high),
        .rd_low_i  (rd_uv_low),
        .pair_o    (uv_pair)
    );

    // ------------------------------------------------------------
    // bus answer: data captured in setup, pready in access
    // ------------------------------------------------------------
    always_comb begin
        state_nxt         = state_r;
        state_nxt.pready  = 1'b0;
        state_nxt.pslverr = 1'b0;
        if (psel_i && !penable_i) begin
            state_nxt.pready = 1'b1;
            state_nxt.prdata = 32'h0000_0000;
            if (pwrite_i || paddr_i[1:0] != 2'h0) begin
                state_nxt.pslverr = 1'b1; // all registers read-only
            end else begin
                unique case (idx)
                    `TDR_OV_HIGH_IDX:
                        state_nxt.prdata[7:0] = ov_pair.high;
                    `TDR_OV_LOW_IDX:
                        state_nxt.prdata[7:0] = ov_pair.low;
                    `TDR_UV_HIGH_IDX:
                        state_nxt.prdata[7:0] = uv_pair.high;
                    `TDR_UV_LOW_IDX:
                        state_nxt.prdata[7:0] = uv_pair.low;
                    default: state_nxt.pslverr = 1'b1;
                endcase
            end
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign pready_o  = state_r.pready;
    assign pslverr_o = state_r.pslverr;
    assign prdata_o  = state_r.prdata;

endmodule

// File: logic/tdr_regs.svh
`ifndef TDR_REGS_SVH
`define TDR_REGS_SVH

// register indices as printed; byte address is index times four
`define TDR_OV_HIGH_IDX    16'h05C2
`define TDR_OV_LOW_IDX     16'h05C3
`define TDR_UV_HIGH_IDX    16'h05C4
`define TDR_UV_LOW_IDX     16'h05C5

// reset values
`define TDR_OV_HIGH_RST    8'h80
`define TDR_OV_LOW_RST     8'h00
`define TDR_UV_HIGH_RST    8'h80
`define TDR_UV_LOW_RST     8'h00

// threshold to dac output scale, 0.8 as numerator over denominator
`define TDR_SCALE_NUM      4'h4
`define TDR_SCALE_DEN      4'h5

// apb register index width; paddr_i itself is 18 bits
`define TDR_ADDR_W         16

`endif

// File: logic/tdr_pkg.sv
package tdr_pkg;

    // one captured conversion from the auxiliary adc
    typedef struct packed {
        logic        valid;
        logic [15:0] result;
    } tdr_conv_s;

    // apb request as seen by the slave
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
    } tdr_apb_req_s;

    // apb answer
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } tdr_apb_rsp_s;

    // lock state of one high/low pair
    typedef enum logic [1:0] {
        TDR_OPEN   = 2'b01,
        TDR_LOCKED = 2'b10
    } tdr_lock_e;

    // state of one readback pair
    typedef struct packed {
        tdr_lock_e  lock;
        logic [7:0] high;
        logic [7:0] low;
    } tdr_pair_s;

endpackage

// File: logic/tdr_pair.sv
`timescale 1ns/10ps
`include "tdr_regs.svh"

// one high/low readback pair with low-byte freeze
module tdr_pair #(
    parameter logic [7:0] HIGH_RST = 8'h80,
    parameter logic [7:0] LOW_RST  = 8'h00
) (
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    input  wire tdr_pkg::tdr_conv_s  conv_i,
    input  wire logic                rd_high_i,
    input  wire logic                rd_low_i,
    output tdr_pkg::tdr_pair_s       pair_o
);

    tdr_pkg::tdr_pair_s pair_r;
    tdr_pkg::tdr_pair_s pair_nxt;

    // high byte always tracks; low byte held while locked
    always_comb begin
        pair_nxt = pair_r;
        if (conv_i.valid) begin
            pair_nxt.high = conv_i.result[15:8];
            if (pair_r.lock == tdr_pkg::TDR_OPEN && !rd_high_i) begin
                pair_nxt.low = conv_i.result[7:0];
            end
        end
        unique case (pair_r.lock)
            tdr_pkg::TDR_OPEN: begin
                if (rd_high_i) begin
                    pair_nxt.lock = tdr_pkg::TDR_LOCKED;
                end
            end
            tdr_pkg::TDR_LOCKED: begin
                if (rd_low_i) begin
                    pair_nxt.lock = tdr_pkg::TDR_OPEN;
                end
            end
            default: pair_nxt.lock = tdr_pkg::TDR_OPEN;
        endcase
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pair_r.lock <= tdr_pkg::TDR_OPEN;
            pair_r.high <= HIGH_RST;
            pair_r.low  <= LOW_RST;
        end else begin
            pair_r <= pair_nxt;
        end
    end

    assign pair_o = pair_r;

endmodule

// File: testbench/tdr_top_monitor.sv
`timescale 1ns/10ps
// ----
// readback checker
// ----
module tdr_top_monitor (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic [15:0] ov_thresh_i,
    input wire logic        ov_conv_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [17:0] paddr_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [31:0] prdata_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic        setup, rd_hi, rd_lo, lk_r;
    logic [15:0] cv_r;
    logic [15:0] cv_new;
    logic [7:0]  lv_r;
    // scaled value of the conversion now offered
    assign cv_new = 16'(({16'h0000, ov_thresh_i} * 32'h4) / 32'h5);
    // setup cycles of the watched reads
    assign setup = psel_i && !penable_i;
    assign rd_hi = setup && !pwrite_i && paddr_i == 18'h01708;
    assign rd_lo = setup && !pwrite_i && paddr_i == 18'h0170C;
    // latest conversion and the frozen low byte
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cv_r <= 16'h8000;
            lk_r <= 1'b0;
            lv_r <= 8'h00;
        end else begin
            if (ov_conv_i)
                cv_r <= cv_new;
            if (ov_conv_i && !lk_r && !rd_hi)
                lv_r <= cv_new[7:0];
            if (rd_hi)
                lk_r <= 1'b1;
            else if (rd_lo)
                lk_r <= 1'b0;
        end
    end
    a_hi_result: assert property (rd_hi && !ov_conv_i |=> pready_o
        && !pslverr_o && prdata_o == {24'h000000, cv_r[15:8]})
        else $error("high byte read wrong");
    a_lo_frozen: assert property (rd_lo && lk_r |=>
        prdata_o == {24'h000000, lv_r}) else $error("low byte not frozen");
    a_lo_live: assert property (rd_lo && !lk_r && !ov_conv_i |=>
        prdata_o[7:0] == lv_r) else $error("low byte not live");
    a_write_refused: assert property (setup && pwrite_i |=> pready_o
        && pslverr_o && prdata_o == 32'h0) else $error("write not refused");
    a_byte_wide: assert property (pready_o && !pslverr_o |->
        prdata_o[31:8] == 24'h000000) else $error("upper bits set");
    cover property (rd_hi);
    cover property (rd_lo && lk_r);
    cover property (setup && pwrite_i);
endmodule

bind tdr_top tdr_top_monitor mon_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .ov_thresh_i(ov_thresh_i), .ov_conv_i(ov_conv_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o));

// File: testbench/tdr_top_tb.sv
`timescale 1ns/10ps
module tdr_top_tb;
    logic        clk_i, rst_n_i, ov_conv_i, uv_conv_i, er;
    logic        psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [15:0] ov_thresh_i, uv_thresh_i;
    logic [17:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    int          miscompares, n_tests;
    tdr_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .ov_thresh_i(ov_thresh_i), .uv_thresh_i(uv_thresh_i),
        .ov_conv_i(ov_conv_i), .uv_conv_i(uv_conv_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .prdata_o(prdata_o));
    // ----
    // shared tasks
    // ----
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic tally_and_finish();
        $display("mismatches %0d of %0d", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [17:0] a);
        int i;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        @(posedge clk_i);
        penable_i <= 1'b1;
        for (i = 0; i < 16 && pready_o !== 1'b1; i++)
            @(posedge clk_i);
        if (pready_o !== 1'b1) begin
            miscompares++;
            tally_and_finish();
        end
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // one conversion pulse, ov or uv
    task automatic conv(input logic u, input logic [15:0] t);
        @(posedge clk_i);
        if (u) begin
            uv_thresh_i <= t;
            uv_conv_i <= 1'b1;
        end else begin
            ov_thresh_i <= t;
            ov_conv_i <= 1'b1;
        end
        @(posedge clk_i);
        ov_conv_i <= 1'b0;
        uv_conv_i <= 1'b0;
    endtask
    // expected high or low byte of 0.8 times a threshold
    function automatic logic [31:0] exp_b(input logic [15:0] t,
                                          input logic        hi);
        logic [15:0] s;
        s = 16'(({16'h0000, t} * 32'h4) / 32'h5);
        return hi ? {24'h000000, s[15:8]} : {24'h000000, s[7:0]};
    endfunction
    // ----
    // scenarios
    // ----
    task automatic t_reset();
        apb(1'b0, 18'h01708);
        chk(rd, 32'h0000_0080);
        chk({31'h0, er}, 32'h0);
        apb(1'b0, 18'h0170C);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 18'h01710);
        chk(rd, 32'h0000_0080);
        apb(1'b0, 18'h01714);
        chk(rd, 32'h0000_0000);
    endtask
    task automatic t_lock();
        conv(1'b0, 16'h1234);
        apb(1'b0, 18'h01708);
        chk(rd, exp_b(16'h1234, 1'b1));
        conv(1'b0, 16'hFFFF);
        apb(1'b0, 18'h0170C);
        chk(rd, exp_b(16'h1234, 1'b0));
        conv(1'b0, 16'hFFFF);
        apb(1'b0, 18'h0170C);
        chk(rd, exp_b(16'hFFFF, 1'b0));
        apb(1'b0, 18'h01708);
        chk(rd, exp_b(16'hFFFF, 1'b1));
        conv(1'b0, 16'h1234);
        apb(1'b0, 18'h0170C);
        chk(rd, exp_b(16'hFFFF, 1'b0));
        apb(1'b0, 18'h01708);
        chk(rd, exp_b(16'h1234, 1'b1));
    endtask
    task automatic t_uv();
        conv(1'b1, 16'hABCD);
        apb(1'b0, 18'h01710);
        chk(rd, exp_b(16'hABCD, 1'b1));
        apb(1'b0, 18'h01714);
        chk(rd, exp_b(16'hABCD, 1'b0));
    endtask
    task automatic t_refuse();
        apb(1'b1, 18'h01708);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b0, 18'h02000);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 18'h01709);
        chk({31'h0, er}, 32'h1);
    endtask
    // reset, then every scenario in turn
    initial begin
        {rst_n_i, ov_conv_i, uv_conv_i, psel_i, penable_i, pwrite_i} = 6'h0;
        ov_thresh_i = 16'h0;
        uv_thresh_i = 16'h0;
        paddr_i = 18'h0;
        pwdata_i = 32'hA5A5A5A5;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_lock();
        t_uv();
        t_refuse();
        tally_and_finish();
    end
endmodule
